// File: core/pif_map.vh
// Register map, field positions and reset values of the peripheral flag block.
// Included by the top-level design file of the block only; definitions only.
`ifndef PIF_MAP_VH
`define PIF_MAP_VH

// Byte offsets on the Wishbone bus, one 32-bit word each
`define PIF_ADR_FLAGS_A 8'h00
`define PIF_ADR_FLAGS_B 8'h04
`define PIF_ADR_ENABLE_A 8'h08
`define PIF_ADR_ENABLE_B 8'h0C
`define PIF_ADR_CONTROL 8'h10
`define PIF_ADR_EVT_STATUS 8'h14
`define PIF_ADR_EVT_MASK 8'h18

// Flag register A layout
`define PIF_BIT_COMPARATOR_TWO 6
`define PIF_BIT_COMPARATOR_ONE 5
`define PIF_BIT_BUS_COLLISION 3
`define PIF_BIT_OSC_SYNTH 2
`define PIF_IMPL_FLAGS_A 8'h6C

// Flag register B layout
`define PIF_BIT_LOGIC_CELL_TWO 1
`define PIF_BIT_LOGIC_CELL_ONE 0
`define PIF_IMPL_FLAGS_B 8'h03

// Control register layout
`define PIF_BIT_GLOBAL_EN 7
`define PIF_BIT_PERIPH_EN 6
`define PIF_IMPL_CONTROL 8'hC0

// Event status and mask: one bit per source
`define PIF_EVT_WIDTH 6
`define PIF_EVT_COMP_ONE 0
`define PIF_EVT_COMP_TWO 1
`define PIF_EVT_BUS_COLL 2
`define PIF_EVT_OSC_SYNTH 3
`define PIF_EVT_CELL_ONE 4
`define PIF_EVT_CELL_TWO 5

// Reset values
`define PIF_RST_FLAGS 8'h00
`define PIF_RST_ENABLE 8'h00
`define PIF_RST_CONTROL 8'h00
`define PIF_RST_EVT 6'h00

`endif

// File: core/pif_flag_reg.v
// One 8-bit pending-flag register with software read/write access.
// Assumes set inputs and write strobe are on sys_clk; no synchronisation.
`timescale 1ns/1ps
`default_nettype none

module pif_flag_reg #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] IMPL_MASK = {WIDTH{1'b1}},
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Software write
    input wire wr_en,
    input wire [WIDTH-1:0] wr_data,
    // Hardware set conditions
    input wire [WIDTH-1:0] set_vec,
    // Stored flags
    output reg [WIDTH-1:0] flags_reg
);

    reg [WIDTH-1:0] flags_next;

    always @* begin
        flags_next = wr_en ? wr_data : flags_reg;
        // Hardware set is ORed last so it beats a clearing write in the same cycle
        flags_next = (flags_next | set_vec) & IMPL_MASK;
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            flags_reg <= RESET_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule // pif_flag_reg

`default_nettype wire

// File: core/pif_evt_status.v
// Sticky event status with write-one-to-clear and a mask of the same layout.
// Assumes events and strobes are on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pif_evt_status #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Events
    input wire [WIDTH-1:0] event_vec,
    // Software access
    input wire clr_en,
    input wire [WIDTH-1:0] clr_data,
    input wire mask_wr,
    input wire [WIDTH-1:0] mask_data,
    // State
    output reg [WIDTH-1:0] status_reg,
    output reg [WIDTH-1:0] mask_reg,
    output wire irq_pending
);

    reg [WIDTH-1:0] status_next;

    always @* begin
        status_next = clr_en ? (status_reg & ~clr_data) : status_reg;
        status_next = status_next | event_vec;
    end

    assign irq_pending = |(status_reg & mask_reg);

    always @(posedge sys_clk) begin
        if (rst) begin
            status_reg <= {WIDTH{1'b0}};
            mask_reg <= {WIDTH{1'b0}};
        end else begin
            status_reg <= status_next;
            if (mask_wr) begin
                mask_reg <= mask_data;
            end
        end
    end

endmodule // pif_evt_status

`default_nettype wire

// File: core/pif_top.v
// Peripheral interrupt flag block: two flag registers, their enables,
// the peripheral gate and an event interrupt, behind a classic Wishbone slave.
// Assumes all peripheral conditions come from logic clocked by sys_clk.
// Assumes the bus master holds each request until it sees the ack.
//
// What this block does
// - Flags set regardless of any enable bits
// - Flag one means pending, zero means none
// - Register A: bits 6,5,3,2; others zero
// - Register B: bits 1,0; bits 7-2 zero
// - Request needs flag, enable and peripheral enable
//
// The implementer's own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pif_map.vh"

module pif_top #(
    parameter ADR_WIDTH = 8
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_WIDTH-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Peripheral interrupt conditions
    input wire comparator_one_cond,
    input wire comparator_two_cond,
    input wire serial_bus_collision_cond,
    input wire osc_synth_cond,
    input wire logic_cell_one_cond,
    input wire logic_cell_two_cond,
    // Interrupt outputs
    output reg cpu_irq_req,
    output reg evt_irq
);

    // Bus handshake
    wire bus_req;
    wire wr_strobe;
    wire lane0_wr;
    reg [31:0] rd_data_next;

    // Register contents
    wire [7:0] periph_irq_flags_a;
    wire [7:0] periph_irq_flags_b;
    reg [7:0] enable_a_reg;
    reg [7:0] enable_b_reg;
    reg [7:0] irq_control_reg;
    wire [`PIF_EVT_WIDTH-1:0] evt_status;
    wire [`PIF_EVT_WIDTH-1:0] evt_mask;
    wire evt_pending;

    // Flag set vectors and per-register writes
    reg [7:0] set_a;
    reg [7:0] set_b;
    wire wr_flags_a;
    wire wr_flags_b;
    wire wr_evt_status;
    wire wr_evt_mask;
    wire wr_enable_a;
    wire wr_enable_b;
    wire wr_control;
    wire rd_strobe;

    // One-hot address decode, shared by the write strobes and the read mux
    wire hit_flags_a;
    wire hit_flags_b;
    wire hit_enable_a;
    wire hit_enable_b;
    wire hit_control;
    wire hit_evt_status;
    wire hit_evt_mask;

    // Event detection
    reg [7:0] flags_a_prev_reg;
    reg [7:0] flags_b_prev_reg;
    reg [`PIF_EVT_WIDTH-1:0] evt_vec;
    wire [7:0] rise_a;
    wire [7:0] rise_b;

    // Request gate
    wire periph_en;
    wire [7:0] pend_a;
    wire [7:0] pend_b;
    wire pend_any;
    wire cpu_irq_next;

    // Decode one aligned word address against the map
    // The map fits in 5 bits; a narrower address bus would alias words
    function adr_hit;
        input [ADR_WIDTH-1:0] adr;
        input [7:0] offset;
        begin
            adr_hit = (adr == offset[ADR_WIDTH-1:0]);
        end
    endfunction

    // Widen an 8-bit register to a bus word with upper bits zero
    function [31:0] word8;
        input [7:0] val;
        begin
            word8 = {24'h000000, val};
        end
    endfunction

    // Requests are answered one cycle after they appear; the high ack
    // masks the request in that cycle, so a held request is not taken twice.
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_strobe = bus_req & wb_we_i;
    // All registers fit in 8 bits, so only byte lane 0 writes anything
    assign lane0_wr = wr_strobe & wb_sel_i[0];
    assign rd_strobe = bus_req & ~wb_we_i;

    assign hit_flags_a = adr_hit(wb_adr_i, `PIF_ADR_FLAGS_A);
    assign hit_flags_b = adr_hit(wb_adr_i, `PIF_ADR_FLAGS_B);
    assign hit_enable_a = adr_hit(wb_adr_i, `PIF_ADR_ENABLE_A);
    assign hit_enable_b = adr_hit(wb_adr_i, `PIF_ADR_ENABLE_B);
    assign hit_control = adr_hit(wb_adr_i, `PIF_ADR_CONTROL);
    assign hit_evt_status = adr_hit(wb_adr_i, `PIF_ADR_EVT_STATUS);
    assign hit_evt_mask = adr_hit(wb_adr_i, `PIF_ADR_EVT_MASK);

    assign wr_flags_a = lane0_wr & hit_flags_a;
    assign wr_flags_b = lane0_wr & hit_flags_b;
    assign wr_enable_a = lane0_wr & hit_enable_a;
    assign wr_enable_b = lane0_wr & hit_enable_b;
    assign wr_control = lane0_wr & hit_control;
    assign wr_evt_status = lane0_wr & hit_evt_status;
    assign wr_evt_mask = lane0_wr & hit_evt_mask;

    // Condition inputs map straight onto flag positions; no enable
    // term enters here at all.
    always @* begin
        set_a = 8'h00;
        set_a[`PIF_BIT_COMPARATOR_TWO] = comparator_two_cond;
        set_a[`PIF_BIT_COMPARATOR_ONE] = comparator_one_cond;
        set_a[`PIF_BIT_BUS_COLLISION] = serial_bus_collision_cond;
        set_a[`PIF_BIT_OSC_SYNTH] = osc_synth_cond;
        set_b = 8'h00;
        set_b[`PIF_BIT_LOGIC_CELL_TWO] = logic_cell_two_cond;
        set_b[`PIF_BIT_LOGIC_CELL_ONE] = logic_cell_one_cond;
    end

    // Implemented-bit masks keep the unused positions at zero
    pif_flag_reg #(
        .WIDTH(8),
        .IMPL_MASK(`PIF_IMPL_FLAGS_A),
        .RESET_VAL(`PIF_RST_FLAGS)
    ) u_flags_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_flags_a),
        .wr_data(wb_dat_i[7:0]),
        .set_vec(set_a),
        .flags_reg(periph_irq_flags_a)
    );

    pif_flag_reg #(
        .WIDTH(8),
        .IMPL_MASK(`PIF_IMPL_FLAGS_B),
        .RESET_VAL(`PIF_RST_FLAGS)
    ) u_flags_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_flags_b),
        .wr_data(wb_dat_i[7:0]),
        .set_vec(set_b),
        .flags_reg(periph_irq_flags_b)
    );

    // Enables and control; they gate only the request, never the flags.
    // Software ought to clear stale flags before setting an enable, since
    // a leftover flag raises the request at once.
    always @(posedge sys_clk) begin
        if (rst) begin
            enable_a_reg <= `PIF_RST_ENABLE;
            enable_b_reg <= `PIF_RST_ENABLE;
            irq_control_reg <= `PIF_RST_CONTROL;
        end else begin
            if (wr_enable_a) begin
                enable_a_reg <= wb_dat_i[7:0] & `PIF_IMPL_FLAGS_A;
            end
            if (wr_enable_b) begin
                enable_b_reg <= wb_dat_i[7:0] & `PIF_IMPL_FLAGS_B;
            end
            if (wr_control) begin
                irq_control_reg <= wb_dat_i[7:0] & `PIF_IMPL_CONTROL;
            end
        end
    end

    // A flag that goes from clear to set is one event.  Edges are taken
    // from the stored flags, so a level condition held for many cycles
    // still makes a single event.
    always @(posedge sys_clk) begin
        if (rst) begin
            flags_a_prev_reg <= `PIF_RST_FLAGS;
            flags_b_prev_reg <= `PIF_RST_FLAGS;
        end else begin
            flags_a_prev_reg <= periph_irq_flags_a;
            flags_b_prev_reg <= periph_irq_flags_b;
        end
    end

    assign rise_a = periph_irq_flags_a & ~flags_a_prev_reg;
    assign rise_b = periph_irq_flags_b & ~flags_b_prev_reg;

    // Events are numbered by source, not by flag position
    always @* begin
        evt_vec = `PIF_RST_EVT;
        evt_vec[`PIF_EVT_COMP_ONE] = rise_a[`PIF_BIT_COMPARATOR_ONE];
        evt_vec[`PIF_EVT_COMP_TWO] = rise_a[`PIF_BIT_COMPARATOR_TWO];
        evt_vec[`PIF_EVT_BUS_COLL] = rise_a[`PIF_BIT_BUS_COLLISION];
        evt_vec[`PIF_EVT_OSC_SYNTH] = rise_a[`PIF_BIT_OSC_SYNTH];
        evt_vec[`PIF_EVT_CELL_ONE] = rise_b[`PIF_BIT_LOGIC_CELL_ONE];
        evt_vec[`PIF_EVT_CELL_TWO] = rise_b[`PIF_BIT_LOGIC_CELL_TWO];
    end

    pif_evt_status #(
        .WIDTH(`PIF_EVT_WIDTH)
    ) u_evt (
        .sys_clk(sys_clk),
        .rst(rst),
        .event_vec(evt_vec),
        .clr_en(wr_evt_status),
        .clr_data(wb_dat_i[`PIF_EVT_WIDTH-1:0]),
        .mask_wr(wr_evt_mask),
        .mask_data(wb_dat_i[`PIF_EVT_WIDTH-1:0]),
        .status_reg(evt_status),
        .mask_reg(evt_mask),
        .irq_pending(evt_pending)
    );

    // The global enable belongs to the core's own vectoring and is only
    // stored here; the peripheral enable is the gate this block applies.
    assign periph_en = irq_control_reg[`PIF_BIT_PERIPH_EN];
    assign pend_a = periph_irq_flags_a & enable_a_reg;
    assign pend_b = periph_irq_flags_b & enable_b_reg;
    assign pend_any = (|pend_a) | (|pend_b);
    assign cpu_irq_next = periph_en & pend_any;

    // Word map, low byte of each word only:
    //   0x00 flags A, 0x04 flags B
    //   0x08 enable A, 0x0C enable B, same layout as the flags
    //   0x10 control: bit 7 global enable (stored only), bit 6 peripheral enable
    //   0x14 event status, write one to clear
    //   0x18 event mask
    // Unmapped addresses read zero and ignore writes, but are still acknowledged.
    always @* begin
        rd_data_next = 32'h00000000;
        if (hit_flags_a) begin
            rd_data_next = word8(periph_irq_flags_a);
        end else if (hit_flags_b) begin
            rd_data_next = word8(periph_irq_flags_b);
        end else if (hit_enable_a) begin
            rd_data_next = word8(enable_a_reg);
        end else if (hit_enable_b) begin
            rd_data_next = word8(enable_b_reg);
        end else if (hit_control) begin
            rd_data_next = word8(irq_control_reg);
        end else if (hit_evt_status) begin
            rd_data_next = {26'h0, evt_status};
        end else if (hit_evt_mask) begin
            rd_data_next = {26'h0, evt_mask};
        end
    end

    // Registered answer: ack one cycle after the request, data with it
    // Data loads only on reads, so it holds between reads
    always @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_strobe) begin
                wb_dat_o <= rd_data_next;
            end
        end
    end

    // Interrupt outputs straight from flip-flops, one cycle behind state.
    // A condition seen at edge N raises the request after N+1 and the event
    // interrupt after N+2; the stage costs a cycle but keeps glitches off the pins.
    always @(posedge sys_clk) begin
        if (rst) begin
            cpu_irq_req <= 1'b0;
            evt_irq <= 1'b0;
        end else begin
            cpu_irq_req <= cpu_irq_next;
            evt_irq <= evt_pending;
        end
    end

endmodule // pif_top

`default_nettype wire

// File: sim/pif_top_monitor.sv
// Checker on the ports of the peripheral flag block.
// Assumes one clock, synchronous active-high reset, classic Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module pif_top_monitor #(
    parameter ADR_WIDTH = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Conditions
    input wire logic comparator_one_cond,
    input wire logic comparator_two_cond,
    input wire logic serial_bus_collision_cond,
    input wire logic osc_synth_cond,
    input wire logic logic_cell_one_cond,
    input wire logic logic_cell_two_cond,
    // Interrupts
    input wire logic cpu_irq_req,
    input wire logic evt_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = take && wb_we_i;
    wire logic anyc = |{comparator_one_cond, comparator_two_cond, serial_bus_collision_cond,
        osc_synth_cond, logic_cell_one_cond, logic_cell_two_cond};
    chk_ack_follow: assert property (take |=> wb_ack_o)
        else $error("request without ack");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_reset_idle: assert property ($fell(rst) |-> !wb_ack_o && !cpu_irq_req && !evt_irq
        && wb_dat_o == 32'h0) else $error("outputs not idle after reset");
    chk_a_unimpl: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
        (wb_dat_o & 32'hFFFFFF93) == 32'h0) else $error("register A spare bits");
    chk_b_unimpl: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
        (wb_dat_o & 32'hFFFFFFFC) == 32'h0) else $error("register B spare bits");
    chk_irq_cause: assert property ($rose(cpu_irq_req) |-> $past(anyc, 2) || $past(wr, 2))
        else $error("request without cause");
    chk_irq_clear: assert property ($fell(cpu_irq_req) |-> $past(wr, 2))
        else $error("request dropped without write");
    chk_evt_cause: assert property ($rose(evt_irq) |-> $past(anyc, 3) || $past(wr, 2)
        || $past(wr, 3)) else $error("event irq without cause");
    chk_rd_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved between reads");
endmodule // pif_top_monitor
`default_nettype wire

// File: sim/pif_periph_model.sv
// Peripheral side: six interrupt conditions in event order.
// Assumes fire is driven on sys_clk by the bench.
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
    // Clock
    input wire logic sys_clk,
    // Requests from the bench
    input wire logic [5:0] fire,
    // Conditions towards the flag block
    output logic [5:0] cond
);
    // Registered so conditions rise just after an edge, as real logic does
    always @(posedge sys_clk) begin
        cond <= fire;
    end
endmodule // pif_periph_model
`default_nettype wire

// File: sim/pif_top_tb_top.sv
// Bench: bus master, peripheral pulses, queued read checks.
// Assumes design, partner model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module pif_top_tb_top;
    logic sys_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00, d;
    logic [31:0] dat = 32'h0, rd;
    logic ack, irq, eirq;
    logic [5:0] fire = 6'h00, cond;
    logic [31:0] expq[$];
    int n_errors = 0, compares = 0, seed = 24088;
    // Flag bit in register A and B per source, in event order
    logic [7:0] amap[6] = '{8'h20, 8'h40, 8'h08, 8'h04, 8'h00, 8'h00};
    logic [7:0] bmap[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
    pif_periph_model u_per (.sys_clk(sys_clk), .fire(fire), .cond(cond));
    pif_top DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .comparator_one_cond(cond[0]), .comparator_two_cond(cond[1]),
        .serial_bus_collision_cond(cond[2]), .osc_synth_cond(cond[3]),
        .logic_cell_one_cond(cond[4]), .logic_cell_two_cond(cond[5]),
        .cpu_irq_req(irq), .evt_irq(eirq));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk_rd(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %0t read %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_irq(input logic e1, e2);
        @(negedge sys_clk);
        compares++;
        if ({irq, eirq} !== {e1, e2}) begin
            n_errors++;
            $display("mismatch %0t irq %b%b exp %b%b", $time, irq, eirq, e1, e2);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, v, e);
        @(posedge sys_clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, v};
        if (!w) expq.push_back({24'h0, e});
        do @(posedge sys_clk); while (ack !== 1'b1);
        cyc <= 0;
        stb <= 0;
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge sys_clk);
        fire <= v;
        @(posedge sys_clk);
        fire <= 6'h00;
        repeat (4) @(posedge sys_clk);
    endtask
    task close_out();
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Reads are judged where the answer lands, against the oldest note
    always @(posedge sys_clk) begin
        if (ack === 1'b1 && !we) chk_rd(rd, expq.size() ? expq.pop_front() : 'x);
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        $display("mismatch %0t timeout", $time);
        close_out();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 0;
        for (int a = 0; a <= 'h1C; a += 4) wb(0, a[7:0], 0, 0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            wb(0, 8'h00, 0, amap[i]);
            wb(0, 8'h04, 0, bmap[i]);
            chk_irq(0, 0);
            wb(1, 8'h00, 0, 0);
            wb(1, 8'h04, 0, 0);
            wb(0, 8'h00, 0, 0);
        end
        $display("test sources done");
        repeat (8) begin
            d = 8'($random(seed));
            wb(1, 8'h00, d, 0);
            wb(0, 8'h00, 0, d & 8'h6C);
            wb(1, 8'h04, d, 0);
            wb(0, 8'h04, 0, d & 8'h03);
        end
        sel <= 4'h0;
        wb(1, 8'h00, ~d, 0);
        sel <= 4'hF;
        wb(0, 8'h00, 0, d & 8'h6C);
        $display("test access done");
        wb(1, 8'h00, 0, 0);
        wb(1, 8'h04, 0, 0);
        wb(1, 8'h08, 8'h20, 0);
        pulse(6'h01);
        chk_irq(0, 0);
        wb(1, 8'h10, 8'h40, 0);
        chk_irq(1, 0);
        wb(1, 8'h00, 0, 0);
        chk_irq(0, 0);
        pulse(6'h02);
        chk_irq(0, 0);
        wb(0, 8'h00, 0, 8'h40);
        $display("test gating done");
        wb(1, 8'h00, 0, 0);
        wb(1, 8'h14, 8'h3F, 0);
        wb(0, 8'h14, 0, 0);
        wb(1, 8'h18, 8'h01, 0);
        pulse(6'h03);
        wb(0, 8'h14, 0, 8'h03);
        chk_irq(1, 1);
        wb(1, 8'h14, 8'h01, 0);
        wb(0, 8'h14, 0, 8'h02);
        chk_irq(1, 0);
        $display("test events done");
        wb(1, 8'h10, 8'hFF, 0);
        wb(0, 8'h10, 0, 8'hC0);
        chk_irq(1, 0);
        @(posedge sys_clk);
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        wb(0, 8'h00, 0, 0);
        wb(0, 8'h10, 0, 0);
        chk_irq(0, 0);
        $display("test second reset done");
        close_out();
    end
endmodule // pif_top_tb_top
bind pif_top pif_top_monitor #(.ADR_WIDTH(ADR_WIDTH)) u_mon (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .comparator_one_cond(comparator_one_cond), .comparator_two_cond(comparator_two_cond),
    .serial_bus_collision_cond(serial_bus_collision_cond), .osc_synth_cond(osc_synth_cond),
    .logic_cell_one_cond(logic_cell_one_cond), .logic_cell_two_cond(logic_cell_two_cond),
    .cpu_irq_req(cpu_irq_req), .evt_irq(evt_irq));
`default_nettype wire
